// [hw/lds_pkg.sv]
// Package of constants and types for the LED driver state sequencer
package lds_pkg;
	// Clock rate in kHz
	localparam int unsigned CLK_KHZ          = 125000;
	// Number of LED channels
	localparam int unsigned NUM_CH           = 4;
	// Fault recovery time in ms
	localparam int unsigned RECOVERY_MS      = 100;
	localparam int unsigned RECOVERY_CYC     = RECOVERY_MS * CLK_KHZ;
	// Longest enable low pulse that only clears LED faults, in us
	localparam int unsigned CLR_PULSE_MAX_US = 20;
	localparam int unsigned CLR_PULSE_CYC    = (CLR_PULSE_MAX_US * CLK_KHZ) / 1000;
	// Soft start duration in us (plain default)
	localparam int unsigned SOFT_US          = 1000;
	localparam int unsigned SOFT_CYC         = (SOFT_US * CLK_KHZ) / 1000;
	// Boost start duration in us (plain default)
	localparam int unsigned BOOST_US         = 1000;
	localparam int unsigned BOOST_CYC        = (BOOST_US * CLK_KHZ) / 1000;
	// Ground sense duration in us (plain default)
	localparam int unsigned GSENSE_US        = 10;
	localparam int unsigned GSENSE_CYC       = (GSENSE_US * CLK_KHZ) / 1000;
	// Switch ramp width in bits during soft start
	localparam int unsigned RAMP_W           = 8;
	localparam logic [RAMP_W-1:0] RAMP_FULL  = 8'hff;
	localparam logic [RAMP_W-1:0] RAMP_ZERO  = 8'h00;
	// Sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_POR   = 7'h01,
		ST_WAIT  = 7'h02,
		ST_SOFT  = 7'h04,
		ST_BOOST = 7'h08,
		ST_GSENS = 7'h10,
		ST_RUN   = 7'h20,
		ST_FHOLD = 7'h40
	} lds_state_type;
endpackage : lds_pkg

// [hw/lds_tmr_if.sv]
// Interface carrying a phase timer's load and expiry
interface lds_tmr_if;
	logic start;  // Restart count from zero
	logic run;    // Count while high
	logic done;   // Count reached its limit
	modport ctl (output start, output run, input done);
	modport tmr (input start, input run, output done);
endinterface : lds_tmr_if

// [hw/lds_timer.sv]
// Phase timer: counts enabled cycles up to a limit
module lds_timer #(
	parameter int unsigned LIMIT = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	lds_tmr_if.tmr   tif
);
	localparam int unsigned W = $clog2(LIMIT + 1);
	logic [W-1:0] cnt_ff;      // Elapsed cycles
	logic [W-1:0] nxt_cnt;     // Next count

	// Next count: saturate at limit
	always_comb begin
		nxt_cnt = cnt_ff;
		if (tif.start) begin
			nxt_cnt = '0;
		end else if (tif.run && cnt_ff != W'(LIMIT)) begin
			nxt_cnt = cnt_ff + W'(1);
		end
	end

	// Register count
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign tif.done = (cnt_ff == W'(LIMIT)) && !tif.start;
endmodule : lds_timer

// [hw/lds_sequencer.sv]
// State sequencer of the LED backlight driver
module lds_sequencer
	import lds_pkg::*;
#(
	parameter int unsigned CH       = NUM_CH,
	parameter int unsigned REC_CYC  = RECOVERY_CYC,
	parameter int unsigned SS_CYC   = SOFT_CYC,
	parameter int unsigned BS_CYC   = BOOST_CYC,
	parameter int unsigned GS_CYC   = GSENSE_CYC
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          srst,
	// Power status from regulator monitor
	input  wire logic          regulator_good,
	// Host control pins
	input  wire logic          io_supply_enable_input,
	input  wire logic          pwm_in,
	input  wire logic          sync_in,
	// Analog status
	input  wire logic          system_fault,
	input  wire logic          boost_at_target,
	input  wire logic [CH-1:0] grounded_sense,
	input  wire logic [CH-1:0] open_string_fault,
	input  wire logic [CH-1:0] shorted_string_fault,
	// Power stage controls
	output logic [RAMP_W-1:0]  input_switch_level,
	output logic               boost_enable,
	output logic               boost_ramp,
	output logic               boost_sync,
	output logic [CH-1:0]      sink_enable,
	output logic [CH-1:0]      loop_include,
	// Host status
	output logic               fault_n
);
	// Two-stage synchronisers for pin inputs
	logic [1:0] en_sy_ff, pwm_sy_ff, syn_sy_ff, pg_sy_ff, sf_sy_ff, bt_sy_ff;
	logic [CH-1:0] gnd_s1_ff, gnd_s2_ff, op_s1_ff, op_s2_ff, sh_s1_ff, sh_s2_ff;
	logic en, pwm, pg, sfault, batt;   // Synchronised levels

	// Synchroniser flops; stage one only feeds stage two
	always_ff @(posedge clk) begin
		en_sy_ff  <= {en_sy_ff[0], io_supply_enable_input};
		pwm_sy_ff <= {pwm_sy_ff[0], pwm_in};
		syn_sy_ff <= {syn_sy_ff[0], sync_in};
		pg_sy_ff  <= {pg_sy_ff[0], regulator_good};
		sf_sy_ff  <= {sf_sy_ff[0], system_fault};
		bt_sy_ff  <= {bt_sy_ff[0], boost_at_target};
		gnd_s1_ff <= grounded_sense;
		gnd_s2_ff <= gnd_s1_ff;
		op_s1_ff  <= open_string_fault;
		op_s2_ff  <= op_s1_ff;
		sh_s1_ff  <= shorted_string_fault;
		sh_s2_ff  <= sh_s1_ff;
	end
	assign en     = en_sy_ff[1];
	assign pwm    = pwm_sy_ff[1];
	assign pg     = pg_sy_ff[1];
	assign sfault = sf_sy_ff[1];
	assign batt   = bt_sy_ff[1];

	// Phase timers, one instance each
	lds_tmr_if t_ss ();   // Soft start
	lds_tmr_if t_bs ();   // Boost start
	lds_tmr_if t_gs ();   // Ground sense
	lds_tmr_if t_rc ();   // Fault recovery
	lds_tmr_if t_lo ();   // Enable low pulse length
	lds_timer #(.LIMIT(SS_CYC))  u_ss (.clk(clk), .srst(srst), .tif(t_ss));
	lds_timer #(.LIMIT(BS_CYC))  u_bs (.clk(clk), .srst(srst), .tif(t_bs));
	lds_timer #(.LIMIT(GS_CYC))  u_gs (.clk(clk), .srst(srst), .tif(t_gs));
	lds_timer #(.LIMIT(REC_CYC)) u_rc (.clk(clk), .srst(srst), .tif(t_rc));
	lds_timer #(.LIMIT(CLR_PULSE_CYC)) u_lo (.clk(clk), .srst(srst), .tif(t_lo));

	// Sequencer state
	lds_state_type     state_ff, nxt_state;
	logic [CH-1:0]     gnd_ff, nxt_gnd;        // Grounded channels
	logic [CH-1:0]     led_flt_ff, nxt_led_flt; // Failed strings
	logic [RAMP_W-1:0] ramp_ff, nxt_ramp;      // Input switch drive
	logic              fault_n_ff, nxt_fault_n;
	logic [RAMP_W-1:0] sw_ff;
	logic              ben_ff, bramp_ff, bsync_ff;
	logic [CH-1:0]     sink_ff, loop_ff;
	logic              en_prev_ff;             // Enable one cycle ago, marks its rising edge

	// Timer control follows state; the enable low timer restarts while enable is high
	always_comb begin
		t_ss.start = (state_ff != ST_SOFT);
		t_ss.run   = 1'b1;
		t_bs.start = (state_ff != ST_BOOST);
		t_bs.run   = 1'b1;
		t_gs.start = (state_ff != ST_GSENS);
		t_gs.run   = 1'b1;
		t_rc.start = (state_ff != ST_FHOLD);
		t_rc.run   = 1'b1;
		t_lo.start = en;            // Measures how long enable has been low
		t_lo.run   = (state_ff == ST_RUN);
	end

	// Next state and stored status
	always_comb begin
		nxt_state   = state_ff;
		nxt_gnd     = gnd_ff;
		nxt_led_flt = led_flt_ff;
		nxt_ramp    = ramp_ff;
		nxt_fault_n = fault_n_ff;
		case (state_ff)
			ST_POR: begin
				if (pg) begin
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				nxt_ramp    = RAMP_ZERO;
				// Released here so a restart after a long low starts clean
				nxt_fault_n = 1'b1;
				nxt_led_flt = '0;
				nxt_gnd     = '0;
				if (en) begin
					nxt_state = ST_SOFT;
				end
			end
			ST_SOFT: begin
				// Gradual turn-on limits inrush
				if (ramp_ff != RAMP_FULL) begin
					nxt_ramp = ramp_ff + RAMP_W'(1);
				end
				if (t_ss.done && ramp_ff == RAMP_FULL) begin
					nxt_state = ST_BOOST;
				end
			end
			ST_BOOST: begin
				// Leave once timed out or target reached
				if (t_bs.done || batt) begin
					nxt_state = ST_GSENS;
				end
			end
			ST_GSENS: begin
				nxt_gnd = gnd_ff | gnd_s2_ff;
				if (t_gs.done) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				// Latch string faults; set wins over clear
				nxt_led_flt = led_flt_ff | ((op_s2_ff | sh_s2_ff) & ~gnd_ff);
				if (|nxt_led_flt) begin
					nxt_fault_n = 1'b0;
				end
				if (!en && t_lo.done) begin
					nxt_state = ST_WAIT;
				end else if (en && !t_lo.done && led_flt_ff != '0 && !en_prev_ff) begin
					nxt_led_flt = (op_s2_ff | sh_s2_ff) & ~gnd_ff;
					nxt_fault_n = ~|nxt_led_flt;
				end
			end
			ST_FHOLD: begin
				nxt_fault_n = 1'b0;
				nxt_ramp    = RAMP_ZERO;
				if (t_rc.done && !sfault) begin
					nxt_state   = ST_RUN;
					nxt_fault_n = ~|led_flt_ff;
					nxt_ramp    = RAMP_FULL;
				end
			end
			default: begin
				nxt_state = ST_WAIT;
			end
		endcase
		// System fault overrides from soft start on
		if (sfault && (state_ff == ST_SOFT || state_ff == ST_BOOST ||
			state_ff == ST_GSENS || state_ff == ST_RUN)) begin
			nxt_state   = ST_FHOLD;
			nxt_fault_n = 1'b0;
		end
		if (!pg) begin
			nxt_state = ST_POR;
		end
	end

	// Output decode; all outputs registered
	logic [RAMP_W-1:0] nxt_sw;
	logic              nxt_ben, nxt_bramp, nxt_bsync;
	logic [CH-1:0]     nxt_sink, nxt_loop;
	always_comb begin
		nxt_sw    = RAMP_ZERO;
		nxt_ben   = 1'b0;
		nxt_bramp = 1'b0;
		nxt_bsync = 1'b0;
		nxt_sink  = '0;
		nxt_loop  = '0;
		case (nxt_state)
			ST_SOFT: begin
				nxt_sw = nxt_ramp;
			end
			ST_BOOST, ST_GSENS: begin
				nxt_sw    = RAMP_FULL;
				nxt_ben   = 1'b1;
				nxt_bramp = (nxt_state == ST_BOOST);
				nxt_bsync = syn_sy_ff[1];
			end
			ST_RUN: begin
				nxt_sw    = RAMP_FULL;
				nxt_ben   = 1'b1;
				nxt_bsync = syn_sy_ff[1];
				// Grounded and failed strings stay out of the loop
				nxt_loop  = ~nxt_gnd & ~nxt_led_flt;
				// Enable low blanks LEDs but mode is kept
				nxt_sink  = (pwm && en) ? nxt_loop : '0;
			end
			default: begin
				nxt_sw = RAMP_ZERO;
			end
		endcase
	end

	// State registers; reset lands in wait with outputs off
	always_ff @(posedge clk) begin
		if (srst) begin
			state_ff   <= ST_WAIT;
			gnd_ff     <= '0;
			led_flt_ff <= '0;
			ramp_ff    <= RAMP_ZERO;
			fault_n_ff <= 1'b1;
			en_prev_ff <= 1'b0;
			sw_ff      <= RAMP_ZERO;
			ben_ff     <= 1'b0;
			bramp_ff   <= 1'b0;
			bsync_ff   <= 1'b0;
			sink_ff    <= '0;
			loop_ff    <= '0;
		end else begin
			state_ff   <= nxt_state;
			gnd_ff     <= nxt_gnd;
			led_flt_ff <= nxt_led_flt;
			ramp_ff    <= nxt_ramp;
			fault_n_ff <= nxt_fault_n;
			en_prev_ff <= en;
			sw_ff      <= nxt_sw;
			ben_ff     <= nxt_ben;
			bramp_ff   <= nxt_bramp;
			bsync_ff   <= nxt_bsync;
			sink_ff    <= nxt_sink;
			loop_ff    <= nxt_loop;
		end
	end

	assign input_switch_level = sw_ff;
	assign boost_enable       = ben_ff;
	assign boost_ramp         = bramp_ff;
	assign boost_sync         = bsync_ff;
	assign sink_enable        = sink_ff;
	assign loop_include       = loop_ff;
	assign fault_n            = fault_n_ff;

	// Checks next to the logic
	// Outputs and state share one register stage, so hold is checked in the same cycle
	a_hold_all_off: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_FHOLD |-> (!ben_ff && sink_ff == '0 && sw_ff == RAMP_ZERO))
		else $error("Fault hold left power stage on");
	a_hold_fault_low: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_FHOLD && nxt_state == ST_FHOLD |=> !fault_n_ff)
		else $error("Fault output high in fault hold");
	a_wait_start: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_WAIT && en && pg && !sfault |=> state_ff == ST_SOFT)
		else $error("Enable did not start power-up");
	a_por_wait: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_POR && pg |=> state_ff == ST_WAIT)
		else $error("No wait state after regulator good");
	a_soft_ramp: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_SOFT && $past(state_ff) == ST_SOFT && ramp_ff != RAMP_FULL
		|-> ramp_ff == $past(ramp_ff) + RAMP_W'(1))
		else $error("Input switch not ramping");
	a_boost_ramp: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_BOOST |-> (bramp_ff && ben_ff && sw_ff == RAMP_FULL))
		else $error("Boost ramp not shown");
	a_gnd_kept: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_RUN && gnd_ff[0] |-> ##1 (!loop_ff[0] && !sink_ff[0]))
		else $error("Grounded channel active");
	a_string_stay: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_RUN && en && !sfault && pg && (op_s2_ff != '0) |=> state_ff == ST_RUN)
		else $error("String fault left normal mode");
	a_long_low: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_RUN && !en && t_lo.done && !sfault && pg |=> state_ff == ST_WAIT)
		else $error("Long enable low did not stop");
	// Boost start holds until its timer or the target ends it
	a_boost_hold: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_BOOST && !t_bs.done && !batt && !sfault && pg |=> state_ff == ST_BOOST)
		else $error("Boost start ended early");
	a_low_blank: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_RUN && !en |=> sink_ff == '0)
		else $error("Sinks on while enable low");
	a_wait_release: assert property (@(posedge clk) disable iff (srst)
		state_ff == ST_WAIT |=> fault_n_ff)
		else $error("Fault output held low after wait");
endmodule : lds_sequencer

// [dv/lds_host_model.sv]
// Host model driving enable, brightness and boost sync
module lds_host_model (
	// Clock
	input  wire logic clk,
	// Host pins
	output logic      en,
	output logic      pwm,
	output logic      sync
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sync_on = 1'b0; // Sync runs only when asked
	initial begin
		en   = 1'b0;
		pwm  = 1'b0;
		sync = 1'b0;
	end
	// External sync clock, still when unused
	always @(negedge clk) begin
		if (sync_on)
			sync <= ~sync;
	end
	// Set enable and brightness levels; caller sits at a falling edge
	task automatic drive(input logic e, input logic p);
		en  = e;
		pwm = p;
	endtask : drive
	// Short low pulse that only clears an LED fault
	task automatic low_pulse(input int n);
		en = 1'b0;
		repeat (n) @(negedge clk);
		en = 1'b1;
	endtask : low_pulse
endmodule : lds_host_model

// [dv/tb_top.sv]
// Self-checking bench for the LED driver state sequencer
module tb_top import lds_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int REC = 50; // Shortened recovery time
	logic              clk      = 1'b0; // Bench clock
	logic              srst     = 1'b1; // Sync reset
	logic              reg_good = 1'b0; // Regulator status
	logic              sys_flt  = 1'b0; // System fault
	logic              at_tgt   = 1'b0; // Boost reached target
	logic [3:0]        gnd      = 4'h0; // Grounded sinks
	logic [3:0]        open_f   = 4'h0; // Open strings
	logic [3:0]        short_f  = 4'h0; // Shorted strings
	logic              en, pwm, sync;   // Host pins
	logic [RAMP_W-1:0] sw_lvl;          // Input switch drive
	logic              b_en, b_ramp, b_sync, f_n;
	logic [3:0]        snk, loop;       // Sinks and loop set
	logic [9:0]        exp_q[$];        // Expected outcomes
	int                error_cnt = 0;
	int                n_checks  = 0;
	logic [3:0]        g, m;            // Grounded and live sets
	logic              ps;              // Last sync output
	int                i, c, t, tog;
	// Free running clock
	always #4 clk = ~clk;
	// Plant: boost settles half a cycle after ramping starts
	always @(negedge clk) at_tgt <= b_ramp;
	lds_host_model i_lds_host_model (.clk(clk), .en(en), .pwm(pwm), .sync(sync));
	lds_sequencer #(.REC_CYC(REC), .SS_CYC(20), .BS_CYC(20), .GS_CYC(5)) i_lds_sequencer (
		.clk(clk), .srst(srst), .regulator_good(reg_good), .io_supply_enable_input(en),
		.pwm_in(pwm), .sync_in(sync), .system_fault(sys_flt), .boost_at_target(at_tgt),
		.grounded_sense(gnd), .open_string_fault(open_f), .shorted_string_fault(short_f),
		.input_switch_level(sw_lvl), .boost_enable(b_en), .boost_ramp(b_ramp),
		.boost_sync(b_sync), .sink_enable(snk), .loop_include(loop), .fault_n(f_n));
	// Compare seen against expected, count both
	task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Let outputs settle past the sync flops, then note the outcome
	task automatic note(input logic [9:0] e);
		repeat (8) @(negedge clk);
		exp_q.push_back(e);
	endtask : note
	// Bounded wait for a sink pattern; a timeout ends the run
	task automatic wait_sinks(input logic [3:0] want);
		for (int k = 0; k < 2000 && snk !== want; k++)
			@(negedge clk);
		if (snk !== want) begin
			check("wait", {6'h0, snk}, {6'h0, want});
			give_verdict();
		end
	endtask : wait_sinks
	task automatic give_verdict();
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	// Watcher: the oldest note is compared at a falling edge, clear of the launching edge
	always @(negedge clk) begin
		if (exp_q.size() > 0)
			check("outputs", {f_n, b_en, snk, loop}, exp_q.pop_front());
	end
	// Main sequence
	initial begin
		void'($urandom(32'h730cbd28));
		g = 4'($urandom_range(0, 14)); // At least one live channel
		repeat (3) @(negedge clk);
		srst = 1'b0;
		note(10'h200);
		gnd = g;
		i_lds_host_model.drive(1'b1, 1'b1);
		note(10'h200);
		reg_good = 1'b1;
		i_lds_host_model.sync_on = 1'b1;
		// Switch must pass through partial drive levels
		for (i = 0; i < 400 && sw_lvl === RAMP_ZERO; i++) @(negedge clk);
		check("ramp", {9'h0, sw_lvl === RAMP_ZERO || sw_lvl === RAMP_FULL}, 10'h0);
		if (sw_lvl === RAMP_ZERO) give_verdict();
		wait_sinks(~g);
		note({2'b11, ~g, ~g});
		check("switch", {2'h0, sw_lvl}, {2'h0, RAMP_FULL});
		// Boost sync follows the host clock
		tog = 0;
		for (i = 0; i < 16; i++) begin
			ps = b_sync;
			@(negedge clk);
			if (b_sync !== ps) tog++;
		end
		check("sync", {9'h0, tog >= 8}, 10'h1);
		i_lds_host_model.drive(1'b1, 1'b0);
		note({2'b11, 4'h0, ~g});
		i_lds_host_model.drive(1'b1, 1'b1);
		for (c = 0; c < 3; c++) if (!g[c]) break;
		m = ~g & ~(4'h1 << c);
		// Open then shorted string on one live channel
		for (t = 0; t < 2; t++) begin
			if (t == 0) open_f[c] = 1'b1;
			else short_f[c] = 1'b1;
			note({2'b01, m, m});
			open_f  = 4'h0;
			short_f = 4'h0;
			fork
				i_lds_host_model.low_pulse(300);
				note({2'b01, 4'h0, m});
			join
			note({2'b11, ~g, ~g});
		end
		sys_flt = 1'b1;
		note(10'h000);
		check("switch", {2'h0, sw_lvl}, 10'h0);
		sys_flt = 1'b0;
		repeat (REC - 20) @(negedge clk);
		note(10'h000);
		wait_sinks(~g);
		note({2'b11, ~g, ~g});
		// Long low drops to wait, high again restarts
		i_lds_host_model.drive(1'b0, 1'b1);
		repeat (3000) @(negedge clk);
		note(10'h200);
		i_lds_host_model.drive(1'b1, 1'b1);
		// Boost start shows ramp with the switch fully on
		for (i = 0; i < 1000 && b_ramp !== 1'b1; i++) @(negedge clk);
		check("boost", {7'h0, b_ramp, b_en, sw_lvl === RAMP_FULL}, 10'h7);
		if (b_ramp !== 1'b1) give_verdict();
		wait_sinks(~g);
		note({2'b11, ~g, ~g});
		// Reset in mid-run clears everything, then power-up runs again
		srst = 1'b1;
		note(10'h200);
		srst = 1'b0;
		note(10'h200);
		wait_sinks(~g);
		note({2'b11, ~g, ~g});
		// Every note must have been compared before the verdict
		for (i = 0; i < 4 && exp_q.size() > 0; i++) @(negedge clk);
		check("drained", {6'h0, 4'(exp_q.size())}, 10'h0);
		give_verdict();
	end
endmodule : tb_top
